// ===== hw/tfs_pkg.sv
// Package with register map, reset values and carrier types of the fan status block.
package tfs_pkg;
	localparam logic [7:0] ADDR_PRIMARY_CFG = 8'h00;
	localparam logic [7:0] ADDR_SECONDARY_CFG = 8'h01;
	localparam logic [7:0] ADDR_FAN_LIMIT_STATUS = 8'h02;
	localparam logic [7:0] ADDR_CRIT_INPUT_STATUS = 8'h03;
	localparam logic [7:0] ADDR_TACH_HIGH_LIMIT = 8'h10;
	localparam logic [7:0] RST_PRIMARY_CFG = 8'h90;
	localparam logic [7:0] RST_SECONDARY_CFG = 8'h7f;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_TACH_HIGH_LIMIT = 8'hff;
	localparam int PCFG_MONITOR_BIT = 0;
	localparam int SCFG_PWM_EN_BIT = 0;
	localparam int SCFG_TACH_EN_BIT = 2;
	localparam int SCFG_LOCAL_IRQ_EN_BIT = 4;
	localparam int SCFG_REMOTE_IRQ_EN_BIT = 5;
	localparam int SCFG_DEVICE_RESET_BIT = 7;
	localparam int ST1_ALARM_SPEED = 0;
	localparam int ST1_FAN_FAULT = 1;
	localparam int ST1_REMOTE_HIGH = 2;
	localparam int ST1_REMOTE_LOW = 3;
	localparam int ST1_REMOTE_CRIT = 4;
	localparam int ST1_DIODE_ERR = 5;
	localparam int ST1_LOCAL_HIGH = 6;
	localparam int ST1_LOCAL_LOW = 7;
	localparam int ST2_LOCAL_CRIT = 6;
	localparam int ST2_OVERTEMP_IN = 7;
	localparam int SYNC_STAGES = 2;

	// Condition levels reported by the measurement logic each monitoring cycle.
	typedef struct packed {
		logic alarm_speed;
		logic remote_high;
		logic remote_low;
		logic remote_crit;
		logic local_high;
		logic local_low;
		logic local_crit;
	} tfs_cond_s;

	// Register access strobes from the serial interface.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tfs_req_s;
endpackage

// ===== hw/tfs_sync.sv
// Two-stage synchroniser for a level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module tfs_sync #(
	parameter logic RESET_VALUE = 1'b0
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic reset_in,
	// Level.
	input wire logic async_in,
	output logic sync_out
);
	logic stage1_r;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			stage1_r <= RESET_VALUE;
			sync_out <= RESET_VALUE;
		end else begin
			stage1_r <= async_in;
			sync_out <= stage1_r;
		end
	end
endmodule
`default_nettype wire

// ===== hw/tfs_tach_meter.sv
// Counts monitor ticks between fan speed pulses and flags a slow or stalled fan.
`timescale 1ns/1ps
`default_nettype none
module tfs_tach_meter #(
	parameter int COUNT_W = 8
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic reset_in,
	// Control.
	input wire logic enable_in,
	input wire logic tick_in,
	input wire logic pulse_in,
	input wire logic [COUNT_W-1:0] limit_in,
	// Result.
	output logic [COUNT_W-1:0] count_out,
	output logic slow_out
);
	logic [COUNT_W-1:0] run_r;
	logic pulse_d_r;
	logic rise;

	assign rise = pulse_in && !pulse_d_r;

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pulse_d_r <= 1'b0;
		end else begin
			pulse_d_r <= pulse_in;
		end
	end

	// The running count saturates at all ones; a stalled fan leaves count_out at its last interval.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			run_r <= '0;
			count_out <= '0;
		end else if (!enable_in) begin
			run_r <= '0;
		end else if (rise) begin
			count_out <= run_r;
			run_r <= '0;
		end else if (tick_in && run_r != '1) begin
			run_r <= run_r + 1'b1;
		end
	end

	// A slow fan is one whose interval passes the limit, stalled or not.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			slow_out <= 1'b0;
		end else begin
			slow_out <= enable_in && (count_out > limit_in || run_r > limit_in);
		end
	end
endmodule
`default_nettype wire

// ===== hw/tfs_regs.sv
// Configuration and status register bank of the temperature monitor and fan controller.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Fan drive output runs only while secondary config bit 0 is one.
// - Fan speed pulses are measured only while secondary config bit 2 is one.
// - Secondary config bit 4 gates local channel interrupts.
// - Bit 5 gates remote interrupts; resets one, cleared on power-up diode fault.
// - Writing one to bit 7 resets the device; bit self-clears, reads zero.
// - Alarm speed flag does not re-set after a read while alarm continues.
// - Fan fault flag re-sets each monitoring cycle while failure persists.
// - Remote high flag re-sets each monitoring cycle while above limit.
// - Remote low flag re-sets each monitoring cycle while below limit.
// - Remote critical flag clears on read and stays clear while condition lasts.
// - Remote diode error is tested at power-up and not cleared by reading.
// - Local high flag re-sets each monitoring cycle while above limit.
// - Local low flag re-sets each monitoring cycle while below limit.
// - Local critical flag clears on read and stays clear while condition lasts.
// - Overtemperature input low sets a clear-on-read flag and forces full fan speed.
// - Secondary config resets to 7f and primary config to 90.
// - Critical input status resets to zero; bits 0 to 5 read zero.
// - Monitoring cycles run only while primary config bit 0 is one.
// - Fan fault when pulse interval count exceeds tach limit, reset all ones.
module tfs_regs #(
	parameter int TACH_W = 8,
	parameter int CYCLE_LEN = 1024
) (
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// Register access from the serial interface.
	input wire tfs_pkg::tfs_req_s req_in,
	output logic [7:0] rdata_out,
	// Measurement conditions and sensor pins.
	input wire tfs_pkg::tfs_cond_s cond_in,
	input wire logic diode_fault_in,
	input wire logic fan_pulse_in,
	input wire logic overtemp_n_in,
	input wire logic pwm_in,
	// Outputs to the pins and the rest of the device.
	output logic fan_pwm_out,
	output logic fan_pwm_en_out,
	output logic fan_full_speed_out,
	output logic local_irq_out,
	output logic remote_irq_out,
	output logic device_reset_out,
	output logic monitor_en_out,
	output logic [TACH_W-1:0] tach_count_out
);
	localparam int CYC_W = $clog2(CYCLE_LEN);

	logic [7:0] pcfg_r;
	logic [7:0] scfg_r;
	logic [7:0] st1_r;
	logic [1:0] st2_r;
	logic [TACH_W-1:0] tach_limit_r;
	logic [CYC_W-1:0] cyc_cnt_r;
	logic cycle_tick;
	logic alarm_seen_r;
	logic rcrit_seen_r;
	logic lcrit_seen_r;
	logic sreset_r;
	logic post_r;
	logic fan_slow;
	logic pulse_sync;
	logic ot_n_sync;
	logic wr_s1;
	logic rd_s1;
	logic rd_s2;
	logic [7:0] st1_set;
	logic [TACH_W-1:0] tach_count;

	function automatic logic hit(input tfs_pkg::tfs_req_s r, input logic [7:0] a);
		hit = r.addr == a;
	endfunction

	assign rd_s1 = req_in.rd && hit(req_in, tfs_pkg::ADDR_FAN_LIMIT_STATUS);
	assign rd_s2 = req_in.rd && hit(req_in, tfs_pkg::ADDR_CRIT_INPUT_STATUS);
	assign wr_s1 = req_in.wr;

	tfs_sync u_pulse_sync (
		.clk_in(ref_clk_in),
		.reset_in(reset_in),
		.async_in(fan_pulse_in),
		.sync_out(pulse_sync)
	);

	tfs_sync #(.RESET_VALUE(1'b1)) u_ot_sync (
		.clk_in(ref_clk_in),
		.reset_in(reset_in),
		.async_in(overtemp_n_in),
		.sync_out(ot_n_sync)
	);

	tfs_tach_meter #(.COUNT_W(TACH_W)) u_tach (
		.clk_in(ref_clk_in),
		.reset_in(reset_in),
		.enable_in(pcfg_r[tfs_pkg::PCFG_MONITOR_BIT] && scfg_r[tfs_pkg::SCFG_TACH_EN_BIT]),
		.tick_in(1'b1),
		.pulse_in(pulse_sync),
		.limit_in(tach_limit_r),
		.count_out(tach_count),
		.slow_out(fan_slow)
	);

	// ==========================================================
	// Monitoring cycle timer.
	// ==========================================================
	assign cycle_tick = pcfg_r[tfs_pkg::PCFG_MONITOR_BIT] && cyc_cnt_r == CYC_W'(CYCLE_LEN - 1);

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cyc_cnt_r <= '0;
		end else if (sreset_r || !pcfg_r[tfs_pkg::PCFG_MONITOR_BIT] || cycle_tick) begin
			cyc_cnt_r <= '0;
		end else begin
			cyc_cnt_r <= cyc_cnt_r + 1'b1;
		end
	end

	// ==========================================================
	// Configuration registers.
	// ==========================================================
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			pcfg_r <= tfs_pkg::RST_PRIMARY_CFG;
			scfg_r <= tfs_pkg::RST_SECONDARY_CFG;
			tach_limit_r <= tfs_pkg::RST_TACH_HIGH_LIMIT;
			sreset_r <= 1'b0;
		end else if (sreset_r) begin
			pcfg_r <= tfs_pkg::RST_PRIMARY_CFG;
			scfg_r <= tfs_pkg::RST_SECONDARY_CFG;
			tach_limit_r <= tfs_pkg::RST_TACH_HIGH_LIMIT;
			sreset_r <= 1'b0;
		end else begin
			if (post_r && diode_fault_in) begin
				scfg_r[tfs_pkg::SCFG_REMOTE_IRQ_EN_BIT] <= 1'b0;
			end
			if (wr_s1 && hit(req_in, tfs_pkg::ADDR_PRIMARY_CFG)) begin
				pcfg_r <= req_in.wdata;
			end
			if (wr_s1 && hit(req_in, tfs_pkg::ADDR_SECONDARY_CFG)) begin
				scfg_r <= {1'b0, req_in.wdata[6:0]};
				sreset_r <= req_in.wdata[tfs_pkg::SCFG_DEVICE_RESET_BIT];
			end
			if (wr_s1 && hit(req_in, tfs_pkg::ADDR_TACH_HIGH_LIMIT)) begin
				tach_limit_r <= req_in.wdata[TACH_W-1:0];
			end
		end
	end

	// One-shot power-up test window for the remote diode.
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			post_r <= 1'b1;
		end else begin
			post_r <= sreset_r;
		end
	end

	// ==========================================================
	// Status register one.
	// ==========================================================
	always_comb begin
		st1_set = '0;
		if (cycle_tick) begin
			st1_set[tfs_pkg::ST1_ALARM_SPEED] = cond_in.alarm_speed && !alarm_seen_r;
			st1_set[tfs_pkg::ST1_FAN_FAULT] = fan_slow;
			st1_set[tfs_pkg::ST1_REMOTE_HIGH] = cond_in.remote_high;
			st1_set[tfs_pkg::ST1_REMOTE_LOW] = cond_in.remote_low;
			st1_set[tfs_pkg::ST1_REMOTE_CRIT] = cond_in.remote_crit && !rcrit_seen_r;
			st1_set[tfs_pkg::ST1_LOCAL_HIGH] = cond_in.local_high;
			st1_set[tfs_pkg::ST1_LOCAL_LOW] = cond_in.local_low;
		end
		st1_set[tfs_pkg::ST1_DIODE_ERR] = post_r && diode_fault_in;
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			st1_r <= tfs_pkg::RST_STATUS;
		end else if (sreset_r) begin
			st1_r <= tfs_pkg::RST_STATUS;
		end else if (rd_s1) begin
			st1_r <= (st1_r & (8'h01 << tfs_pkg::ST1_DIODE_ERR)) | st1_set;
		end else begin
			st1_r <= st1_r | st1_set;
		end
	end

	// Conditions that do not re-set while they persist are remembered until they end.
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			alarm_seen_r <= 1'b0;
			rcrit_seen_r <= 1'b0;
			lcrit_seen_r <= 1'b0;
		end else if (sreset_r) begin
			alarm_seen_r <= 1'b0;
			rcrit_seen_r <= 1'b0;
			lcrit_seen_r <= 1'b0;
		end else if (cycle_tick) begin
			alarm_seen_r <= cond_in.alarm_speed;
			rcrit_seen_r <= cond_in.remote_crit;
			lcrit_seen_r <= cond_in.local_crit;
		end
	end

	// ==========================================================
	// Status register two.
	// ==========================================================
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			st2_r <= '0;
		end else if (sreset_r) begin
			st2_r <= '0;
		end else begin
			st2_r[0] <= (st2_r[0] && !rd_s2)
				|| (cycle_tick && cond_in.local_crit && !lcrit_seen_r);
			st2_r[1] <= (st2_r[1] && !rd_s2) || !ot_n_sync;
		end
	end

	// ==========================================================
	// Read data and outputs.
	// ==========================================================
	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			rdata_out <= 8'h00;
		end else if (req_in.rd) begin
			unique case (req_in.addr)
				tfs_pkg::ADDR_PRIMARY_CFG: rdata_out <= pcfg_r;
				tfs_pkg::ADDR_SECONDARY_CFG: rdata_out <= scfg_r;
				tfs_pkg::ADDR_FAN_LIMIT_STATUS: rdata_out <= st1_r;
				tfs_pkg::ADDR_CRIT_INPUT_STATUS: rdata_out <= {st2_r, 6'h00};
				tfs_pkg::ADDR_TACH_HIGH_LIMIT: rdata_out <= 8'(tach_limit_r);
				default: rdata_out <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			fan_pwm_out <= 1'b0;
			fan_pwm_en_out <= 1'b0;
			fan_full_speed_out <= 1'b0;
			local_irq_out <= 1'b0;
			remote_irq_out <= 1'b0;
			device_reset_out <= 1'b0;
			monitor_en_out <= 1'b0;
			tach_count_out <= '0;
		end else begin
			fan_pwm_en_out <= scfg_r[tfs_pkg::SCFG_PWM_EN_BIT];
			fan_full_speed_out <= !ot_n_sync || st2_r[1];
			fan_pwm_out <= scfg_r[tfs_pkg::SCFG_PWM_EN_BIT]
				&& (pwm_in || !ot_n_sync || st2_r[1]);
			local_irq_out <= scfg_r[tfs_pkg::SCFG_LOCAL_IRQ_EN_BIT]
				&& (st1_r[tfs_pkg::ST1_LOCAL_HIGH] || st1_r[tfs_pkg::ST1_LOCAL_LOW]
				|| st2_r[0]);
			remote_irq_out <= scfg_r[tfs_pkg::SCFG_REMOTE_IRQ_EN_BIT]
				&& (|st1_r[tfs_pkg::ST1_DIODE_ERR:tfs_pkg::ST1_REMOTE_HIGH]);
			device_reset_out <= sreset_r;
			monitor_en_out <= pcfg_r[tfs_pkg::PCFG_MONITOR_BIT];
			tach_count_out <= tach_count;
		end
	end
endmodule
`default_nettype wire

// ===== verif/tfs_regs_assertions.sv
// Checker of the register bank port behaviour.
`timescale 1ns/1ps
`default_nettype none
module tfs_regs_chk (
	// Clock, reset and access.
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire tfs_pkg::tfs_req_s req_in,
	input wire logic [7:0] rdata_out,
	input wire logic overtemp_n_in,
	// Outputs.
	input wire logic fan_pwm_out,
	input wire logic fan_pwm_en_out,
	input wire logic fan_full_speed_out,
	input wire logic local_irq_out,
	input wire logic remote_irq_out,
	input wire logic device_reset_out,
	input wire logic monitor_en_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	logic w1;
	assign w1 = req_in.wr && req_in.addr == 8'h01;
	AST_PWM_OFF: assert property (!fan_pwm_en_out && !fan_full_speed_out |-> !fan_pwm_out)
		else $error("fan drive active while disabled");
	AST_PWM_ON: assert property (w1 && req_in.wdata[0] && !req_in.wdata[7] |-> ##[1:2] fan_pwm_en_out)
		else $error("fan drive enable not taken");
	AST_SRST: assert property (w1 && req_in.wdata[7] |-> ##[1:2] device_reset_out)
		else $error("device reset not issued");
	AST_SRST_PULSE: assert property (device_reset_out |=> !device_reset_out)
		else $error("device reset longer than one cycle");
	AST_SCFG_B7: assert property (req_in.rd && req_in.addr == 8'h01 |=> !rdata_out[7])
		else $error("reset bit reads one");
	AST_ST2_UNUSED: assert property (req_in.rd && req_in.addr == 8'h03 |=> rdata_out[5:0] == 6'h00)
		else $error("unused status bits not zero");
	AST_MON_OFF: assert property (req_in.wr && req_in.addr == 8'h00 && !req_in.wdata[0]
		|-> ##[1:2] !monitor_en_out)
		else $error("monitoring still enabled");
	AST_LIRQ_OFF: assert property (w1 && !req_in.wdata[4] |-> ##[1:2] !local_irq_out)
		else $error("local interrupt not gated");
	AST_RIRQ_OFF: assert property (w1 && !req_in.wdata[5] |-> ##[1:2] !remote_irq_out)
		else $error("remote interrupt not gated");
	AST_OVT: assert property ($fell(overtemp_n_in) |-> ##[1:4] fan_full_speed_out)
		else $error("no full speed on overtemperature");
endmodule
bind tfs_regs tfs_regs_chk u_chk (.ref_clk_in, .reset_in, .req_in, .rdata_out, .overtemp_n_in,
	.fan_pwm_out, .fan_pwm_en_out, .fan_full_speed_out, .local_irq_out, .remote_irq_out,
	.device_reset_out, .monitor_en_out);
`default_nettype wire

// ===== verif/tfs_fan_model.sv
// Fan side model that makes speed pulses of a set half period.
`timescale 1ns/1ps
`default_nettype none
module tfs_fan_model (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic reset_in,
	// Half period in clock cycles, and the pulse pin.
	input wire logic [7:0] half_in,
	output logic pulse_out
);
	logic [7:0] cnt_r;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cnt_r <= 8'h00;
			pulse_out <= 1'b0;
		end else if (cnt_r >= half_in - 8'h01) begin
			cnt_r <= 8'h00;
			pulse_out <= !pulse_out;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench of the register bank.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, rst, dio, ovt_n, pls, pwm_o, pen, fsp, lirq, rirq;
	logic [7:0] rd, hlf, v, tc;
	logic mon;
	tfs_pkg::tfs_req_s req;
	tfs_pkg::tfs_cond_s cnd;
	int n_fail = 0;
	int comparisons = 0;
	tfs_regs #(.TACH_W(8), .CYCLE_LEN(16)) u_dut (.ref_clk_in(clk), .reset_in(rst),
		.req_in(req), .rdata_out(rd), .cond_in(cnd), .diode_fault_in(dio), .fan_pulse_in(pls),
		.overtemp_n_in(ovt_n), .pwm_in(1'b1), .fan_pwm_out(pwm_o), .fan_pwm_en_out(pen),
		.fan_full_speed_out(fsp), .local_irq_out(lirq), .remote_irq_out(rirq),
		.device_reset_out(), .monitor_en_out(mon), .tach_count_out(tc));
	tfs_fan_model u_fan (.clk_in(clk), .reset_in(rst), .half_in(hlf), .pulse_out(pls));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		req = '0;
	endtask
	task automatic rdr(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		req = '0;
		@(negedge clk);
		d = rd;
	endtask
	task automatic ck(input string s, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic ckb(input string s, input logic e, input logic g);
		ck(s, {7'h00, e}, {7'h00, g});
	endtask
	task automatic ckr(input logic [7:0] a, input logic [7:0] e);
		rdr(a, v);
		ck($sformatf("register %h", a), e, v);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		req = '0;
		cnd = '0;
		dio = 1'b0;
		ovt_n = 1'b1;
		hlf = 8'h02;
		w(10);
		rst = 1'b0;
		ckr(8'h00, 8'h90);
		ckr(8'h01, 8'h7f);
		ckr(8'h02, 8'h00);
		ckr(8'h03, 8'h00);
		ckb("fan drive", 1'b1, pwm_o);
		wr(8'h01, 8'h7e);
		ckr(8'h01, 8'h7e);
		ckb("fan drive", 1'b0, pwm_o);
		ckb("fan drive enable", 1'b0, pen);
		wr(8'h01, 8'h7f);
		cnd = 7'b1101101;
		wr(8'h00, 8'h91);
		w(40);
		ckb("monitor enable", 1'b1, mon);
		ck("tach interval", 8'h03, tc);
		ckb("local irq", 1'b1, lirq);
		ckb("remote irq", 1'b1, rirq);
		ckr(8'h02, 8'h55);
		ckr(8'h03, 8'h40);
		w(40);
		ckr(8'h02, 8'h44);
		ckr(8'h03, 8'h00);
		cnd = 7'b0010010;
		hlf = 8'h40;
		wr(8'h10, 8'h20);
		w(300);
		rdr(8'h02, v);
		w(40);
		ckr(8'h02, 8'h8a);
		w(40);
		ckr(8'h02, 8'h8a);
		wr(8'h00, 8'h90);
		cnd = '0;
		dio = 1'b1;
		wr(8'h01, 8'h80);
		w(4);
		ckr(8'h01, 8'h5f);
		ckr(8'h00, 8'h90);
		ckb("monitor enable", 1'b0, mon);
		ckr(8'h02, 8'h20);
		ckr(8'h02, 8'h20);
		ckb("remote irq", 1'b0, rirq);
		wr(8'h01, 8'h7f);
		w(3);
		ckb("remote irq", 1'b1, rirq);
		dio = 1'b0;
		ovt_n = 1'b0;
		w(8);
		ckb("full speed", 1'b1, fsp);
		ovt_n = 1'b1;
		w(6);
		ckr(8'h03, 8'h80);
		ckr(8'h03, 8'h00);
		w(2);
		ckb("full speed", 1'b0, fsp);
		tally_and_finish();
	end
endmodule
`default_nettype wire
